//--- hw/spi_fmt_pkg.sv
package spi_fmt_pkg;
    // Round and frame geometry
    localparam int          ROUND_BITS    = 128;
    localparam int          FRAME_BITS    = 32;
    localparam int          MAX_FRAMES    = 4;
    // Clock divider: ratio = 2 * (setting + 1), so 2 up to 4096
    localparam int          DIV_RATIO_MIN = 2;
    localparam int          DIV_RATIO_MAX = 4096;
    localparam int          DIV_W         = 11;
    localparam logic [10:0] DIV_RESET     = 11'h000;
    // Length codes: 0..8 give 8..16 bits, then 20, 24 and 32
    localparam logic [3:0]  CODE_LEN_16   = 4'h8;
    localparam logic [3:0]  CODE_LEN_20   = 4'h9;
    localparam logic [3:0]  CODE_LEN_24   = 4'ha;
    localparam logic [3:0]  CODE_LEN_32   = 4'hb;
    localparam logic [4:0]  LEN_M1_MIN    = 5'h07;
    localparam logic [4:0]  LEN_M1_20     = 5'h13;
    localparam logic [4:0]  LEN_M1_24     = 5'h17;
    localparam logic [4:0]  LEN_M1_32     = 5'h1f;
    // Delay counter reset value, counts divider ticks (two per serial clock)
    localparam logic [3:0]  DLY_RESET     = 4'h0;
    // Master sequencer, Gray coded along idle-lead-transfer-trail-gap
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LEAD  = 3'h1,
        ST_XFER  = 3'h3,
        ST_TRAIL = 3'h2,
        ST_GAP   = 3'h6
    } seq_state_t;
endpackage

//--- hw/word_buffer2.sv
`timescale 1ns/1ps
module word_buffer2 #(
    parameter int WIDTH = 128
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [2];
    logic [WIDTH-1:0] next_mem [2];
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       count;
    logic             next_wr_ptr;
    logic             next_rd_ptr;
    logic [1:0]       next_count;
    logic             push;
    logic             pop;

    // Honest flags: full only with two words held
    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and storage update
    always_comb begin
        next_mem          = mem;
        next_wr_ptr       = wr_ptr;
        next_rd_ptr       = rd_ptr;
        next_count        = count;
        if (push) begin
            next_mem[wr_ptr] = in_data;
            next_wr_ptr      = !wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = !rd_ptr;
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        mem <= next_mem;
        if (srst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end
endmodule

//--- hw/spi_transfer_format_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - Data moves on MOSI, MISO, slave select and serial clock, in 4-wire or 3-wire form.
// - A mode input picks full-duplex or transmit-only shifting.
// - A polarity input sets the idle level of the serial clock, shared with the far end.
// - A phase input picks the sampling edge and the changing edge, shared with the far end.
// - A bit-order input shifts each frame MSB first or LSB first, both directions.
// - Frame length is 8 to 16 bits in single steps, or 20, 24 or 32 bits, nothing else.
// - Transmit and receive rounds are 128 bits, one to four frames of up to 32 bits.
// - Optional byte swap reverses byte order of transmit and receive frames.
// - As master the serial clock is the system clock divided by 2 up to 4096.
// - As master, 1 to 8 serial clocks of delay lead, trail and separate accesses.
// - Mode fault, overrun, parity and underrun errors are detected and flagged.
module spi_transfer_format_unit (
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic         master_mode,
    input  wire logic         three_wire,
    input  wire logic         tx_only,
    input  wire logic         cpol,
    input  wire logic         cpha,
    input  wire logic         lsb_first,
    input  wire logic         byte_swap,
    input  wire logic         parity_en,
    input  wire logic         parity_odd,
    input  wire logic [3:0]   len_code,
    input  wire logic [1:0]   frame_cnt,
    input  wire logic [10:0]  clk_div,
    input  wire logic [2:0]   lead_delay,
    input  wire logic [2:0]   trail_delay,
    input  wire logic [2:0]   next_delay,
    input  wire logic         error_clear,
    input  wire logic [127:0] tx_data,
    input  wire logic         tx_valid,
    output logic              tx_ready,
    output logic [127:0]      rx_data,
    output logic              rx_valid,
    input  wire logic         rx_ready,
    input  wire logic         serial_clock_line_in,
    output logic              serial_clock_line_out,
    output logic              serial_clock_line_oe,
    input  wire logic         slave_select_line_n_in,
    output logic              slave_select_line_n_out,
    output logic              slave_select_line_oe,
    input  wire logic         mosi_in,
    output logic              mosi_out,
    output logic              mosi_oe,
    input  wire logic         miso_in,
    output logic              miso_out,
    output logic              miso_oe,
    output logic              busy,
    output logic              len_error,
    output logic              mode_fault,
    output logic              overrun,
    output logic              parity_error,
    output logic              underrun
);
    // Pin synchronisers: bit 0 clock, 1 select, 2 mosi, 3 miso
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic       prev_act;
    always_ff @(posedge clock) begin
        sync1 <= {miso_in, mosi_in, slave_select_line_n_in, serial_clock_line_in};
        sync2 <= sync1;
        prev_act <= sync2[0] ^ cpol;
    end

    logic [4:0]  len_m1;
    logic [31:0] lmask;
    // Length decode; illegal codes fall back to 8 bits and raise len_error
    always_comb begin
        if (len_code <= spi_fmt_pkg::CODE_LEN_16) begin
            len_m1 = spi_fmt_pkg::LEN_M1_MIN + {1'b0, len_code};
        end else if (len_code == spi_fmt_pkg::CODE_LEN_20) begin
            len_m1 = spi_fmt_pkg::LEN_M1_20;
        end else if (len_code == spi_fmt_pkg::CODE_LEN_24) begin
            len_m1 = spi_fmt_pkg::LEN_M1_24;
        end else if (len_code == spi_fmt_pkg::CODE_LEN_32) begin
            len_m1 = spi_fmt_pkg::LEN_M1_32;
        end else begin
            len_m1 = spi_fmt_pkg::LEN_M1_MIN;
        end
        lmask = 32'hffff_ffff >> (5'h1f - len_m1);
    end

    // Byte reversal: two bytes for 9 to 16 bits, all four bytes beyond 16 bits, none at 8
    function automatic logic [31:0] swap32(input logic [31:0] w, input logic [4:0] m1);
        if (m1 > 5'h0f) begin
            swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
        end else if (m1 > 5'h07) begin
            swap32 = {16'h0000, w[7:0], w[15:8]};
        end else begin
            swap32 = w;
        end
    endfunction

    // Line level of one bit of the round, parity replacing the last bit sent
    function automatic logic line_bit(input logic [127:0] r, input logic [1:0] f,
                                      input logic [4:0] b, input logic [4:0] m1,
                                      input logic [31:0] mk, input logic lsb,
                                      input logic pen, input logic odd);
        logic [31:0] w;
        logic [4:0]  plast;
        w     = r[{f, 5'h00} +: 32];
        plast = lsb ? m1 : 5'h00;
        if (pen && b == m1) begin
            line_bit = ^(w & mk) ^ w[plast] ^ odd;
        end else begin
            line_bit = w[lsb ? b : (m1 - b)];
        end
    endfunction

    spi_fmt_pkg::seq_state_t state;
    spi_fmt_pkg::seq_state_t next_state;
    logic [10:0]  div_cnt;
    logic [10:0]  next_div_cnt;
    logic [3:0]   dcnt;
    logic [3:0]   next_dcnt;
    logic         sck_act;
    logic         next_sck_act;
    logic [4:0]   s_bit;
    logic [4:0]   next_s_bit;
    logic [1:0]   s_frm;
    logic [1:0]   next_s_frm;
    logic [4:0]   r_bit;
    logic [4:0]   next_r_bit;
    logic [1:0]   r_frm;
    logic [1:0]   next_r_frm;
    logic         out_bit;
    logic         next_out_bit;
    logic [127:0] tx_round;
    logic [127:0] next_tx_round;
    logic [127:0] rx_round;
    logic [127:0] next_rx_round;
    logic [31:0]  rx_word;
    logic [31:0]  next_rx_word;
    logic         have_round;
    logic         next_have_round;
    logic         started;
    logic         next_started;
    logic         all_sampled;
    logic         next_all_sampled;
    logic         push_pending;
    logic         next_push_pending;
    logic [4:0]   flags;
    logic [4:0]   next_flags;
    logic         rx_in_ready;
    logic         tick;
    logic         selected;
    logic         lead;
    logic         trail;
    logic         sample;
    logic         shift;
    logic         rbit;
    logic [31:0]  nword;
    logic         load;
    logic         round_done;
    logic [3:0]   dly_end;

    // Main sequencer, shifter and error flags
    always_comb begin
        next_state = state;
        next_div_cnt = div_cnt;
        next_dcnt = dcnt;
        next_sck_act = sck_act;
        next_s_bit = s_bit;
        next_s_frm = s_frm;
        next_r_bit = r_bit;
        next_r_frm = r_frm;
        next_out_bit = out_bit;
        next_tx_round = tx_round;
        next_rx_round = rx_round;
        next_rx_word = rx_word;
        next_have_round = have_round;
        next_started = started;
        next_all_sampled = all_sampled;
        next_push_pending = 1'b0;
        next_flags = error_clear ? 5'h00 : flags; // Errors found below still win over a clear
        nword = rx_word;
        round_done = 1'b0;
        dly_end = 4'h0;
        // Divider tick every clk_div+1 cycles, two ticks per serial clock
        tick = master_mode && (div_cnt == clk_div);
        next_div_cnt = (tick || !master_mode) ? spi_fmt_pkg::DIV_RESET : div_cnt + 11'h001;
        // Without slave select the slave is always addressed
        selected = three_wire || !sync2[1];
        if (master_mode) begin
            lead  = (state == spi_fmt_pkg::ST_XFER) && tick && !sck_act;
            trail = (state == spi_fmt_pkg::ST_XFER) && tick && sck_act;
        end else begin
            lead  = selected && (sync2[0] ^ cpol) && !prev_act;
            trail = selected && !(sync2[0] ^ cpol) && prev_act;
        end
        sample = cpha ? trail : lead;
        shift  = cpha ? lead : trail;
        rbit   = master_mode ? sync2[3] : sync2[2];
        // A new round is taken only between rounds, and as master never while a mode fault is flagged
        load = tx_valid && !started && (master_mode
               ? (state == spi_fmt_pkg::ST_IDLE && !flags[0]) : !have_round);
        if (load) begin
            for (int i = 0; i < spi_fmt_pkg::MAX_FRAMES; i++) begin
                next_tx_round[i*32 +: 32] = byte_swap
                    ? swap32(tx_data[i*32 +: 32], len_m1) : tx_data[i*32 +: 32];
            end
            next_have_round = 1'b1;
            next_s_bit = 5'h00;
            next_s_frm = 2'h0;
            next_r_bit = 5'h00;
            next_r_frm = 2'h0;
            next_all_sampled = 1'b0;
            next_rx_round = 128'h0; // Unused frames read zero, never an older round
        end
        // Phase 0 needs the first bit on the line before the first edge
        if (!started && !cpha) begin
            next_out_bit = have_round ? line_bit(tx_round, 2'h0, 5'h00, len_m1, lmask,
                                                 lsb_first, parity_en, parity_odd) : 1'b0;
        end
        if (shift) begin
            if (!have_round && !started && !master_mode) begin
                next_flags[4] = 1'b1;
            end
            next_started = 1'b1;
            if (!cpha) begin
                next_s_bit = (s_bit == len_m1) ? 5'h00 : s_bit + 5'h01;
                next_s_frm = (s_bit == len_m1) ? s_frm + 2'h1 : s_frm;
                next_out_bit = have_round ? line_bit(tx_round, next_s_frm, next_s_bit,
                                                     len_m1, lmask, lsb_first,
                                                     parity_en, parity_odd) : 1'b0;
            end else begin
                next_out_bit = have_round ? line_bit(tx_round, s_frm, s_bit, len_m1, lmask,
                                                     lsb_first, parity_en, parity_odd) : 1'b0;
                next_s_bit = (s_bit == len_m1) ? 5'h00 : s_bit + 5'h01;
                next_s_frm = (s_bit == len_m1) ? s_frm + 2'h1 : s_frm;
            end
        end
        if (sample) begin
            if (!have_round && !started && !master_mode) begin
                next_flags[4] = 1'b1;
            end
            next_started = 1'b1;
            nword[lsb_first ? r_bit : (len_m1 - r_bit)] = rbit;
            next_rx_word = nword;
            next_r_bit = r_bit + 5'h01;
            if (r_bit == len_m1) begin
                next_r_bit = 5'h00;
                next_rx_word = 32'h0000_0000;
                next_r_frm = r_frm + 2'h1;
                if (!tx_only) begin
                    next_rx_round[{r_frm, 5'h00} +: 32] = byte_swap
                        ? swap32(nword & lmask, len_m1) : (nword & lmask);
                    if (parity_en && ((^(nword & lmask)) != parity_odd)) begin
                        next_flags[3] = 1'b1;
                    end
                end
                if (r_frm == frame_cnt) begin
                    round_done = 1'b1;
                    next_r_frm = 2'h0;
                    next_push_pending = !tx_only;
                    next_all_sampled = 1'b1;
                    if (!master_mode) begin
                        next_have_round = 1'b0;
                        next_started = 1'b0;
                        next_s_bit = 5'h00;
                        next_s_frm = 2'h0;
                    end
                end
            end
        end
        // Finished round meets a full receive buffer
        if (push_pending && !rx_in_ready) begin
            next_flags[2] = 1'b1;
        end
        // Slave released mid round: restart counters, keep the pending data
        if (!master_mode && !selected) begin
            next_started = 1'b0;
            next_s_bit = 5'h00;
            next_s_frm = 2'h0;
            next_r_bit = 5'h00;
            next_r_frm = 2'h0;
            next_rx_word = 32'h0000_0000;
        end
        // Master sequencer with delays in ticks, two per serial clock
        if (tick) begin
            next_dcnt = dcnt + 4'h1;
        end
        case (state)
            spi_fmt_pkg::ST_IDLE: begin
                next_dcnt = spi_fmt_pkg::DLY_RESET;
                next_sck_act = 1'b0;
                if (load) begin
                    next_state = spi_fmt_pkg::ST_LEAD;
                    next_started = 1'b0;
                end
            end
            spi_fmt_pkg::ST_LEAD: begin
                dly_end = {lead_delay, 1'b1};
                if (tick && dcnt == dly_end) begin
                    next_state = spi_fmt_pkg::ST_XFER;
                    next_dcnt = spi_fmt_pkg::DLY_RESET;
                end
            end
            spi_fmt_pkg::ST_XFER: begin
                next_dcnt = spi_fmt_pkg::DLY_RESET;
                if (tick) begin
                    next_sck_act = !sck_act;
                end
                if (trail && (all_sampled || round_done)) begin
                    next_state = spi_fmt_pkg::ST_TRAIL;
                end
            end
            spi_fmt_pkg::ST_TRAIL: begin
                dly_end = {trail_delay, 1'b1};
                if (tick && dcnt == dly_end) begin
                    next_state = spi_fmt_pkg::ST_GAP;
                    next_dcnt = spi_fmt_pkg::DLY_RESET;
                    next_have_round = 1'b0;
                    next_started = 1'b0;
                end
            end
            spi_fmt_pkg::ST_GAP: begin
                dly_end = {next_delay, 1'b1};
                if (tick && dcnt == dly_end) begin
                    next_state = spi_fmt_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = spi_fmt_pkg::ST_IDLE;
            end
        endcase
        // Another master pulls our select low: abort and flag
        if (master_mode && !three_wire && !sync2[1]) begin
            next_flags[1] = 1'b1;
            next_state = spi_fmt_pkg::ST_IDLE;
            next_sck_act = 1'b0;
            next_started = 1'b0;
        end
        if (!master_mode) begin
            next_state = spi_fmt_pkg::ST_IDLE;
            next_sck_act = 1'b0;
        end
        next_flags[0] = next_flags[1];
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state <= spi_fmt_pkg::ST_IDLE;
            div_cnt <= spi_fmt_pkg::DIV_RESET;
            dcnt <= spi_fmt_pkg::DLY_RESET;
            sck_act <= 1'b0;
            s_bit <= 5'h00;
            s_frm <= 2'h0;
            r_bit <= 5'h00;
            r_frm <= 2'h0;
            out_bit <= 1'b0;
            tx_round <= 128'h0;
            rx_round <= 128'h0;
            rx_word <= 32'h0000_0000;
            have_round <= 1'b0;
            started <= 1'b0;
            all_sampled <= 1'b0;
            push_pending <= 1'b0;
            flags <= 5'h00;
            len_error <= 1'b0;
        end else begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            dcnt <= next_dcnt;
            sck_act <= next_sck_act;
            s_bit <= next_s_bit;
            s_frm <= next_s_frm;
            r_bit <= next_r_bit;
            r_frm <= next_r_frm;
            out_bit <= next_out_bit;
            tx_round <= next_tx_round;
            rx_round <= next_rx_round;
            rx_word <= next_rx_word;
            have_round <= next_have_round;
            started <= next_started;
            all_sampled <= next_all_sampled;
            push_pending <= next_push_pending;
            flags <= next_flags;
            len_error <= (len_code > spi_fmt_pkg::CODE_LEN_32);
        end
    end

    // Two-entry buffer lets a slow reader stall for two rounds without losing one
    word_buffer2 #(
        .WIDTH(spi_fmt_pkg::ROUND_BITS)
    ) rx_buffer (
        .clock     (clock),
        .srst      (srst),
        .in_valid  (push_pending),
        .in_ready  (rx_in_ready),
        .in_data   (rx_round),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // Pin drive; the select pin is only an output in 4-wire master mode
    assign tx_ready                = load;
    assign serial_clock_line_out   = sck_act ^ cpol;
    assign serial_clock_line_oe    = master_mode;
    assign slave_select_line_n_out = !(state == spi_fmt_pkg::ST_LEAD
                                       || state == spi_fmt_pkg::ST_XFER
                                       || state == spi_fmt_pkg::ST_TRAIL);
    assign slave_select_line_oe    = master_mode && !three_wire;
    assign mosi_out                = out_bit;
    assign mosi_oe                 = master_mode;
    assign miso_out                = out_bit;
    assign miso_oe                 = !master_mode && selected;
    assign busy                    = started || (state != spi_fmt_pkg::ST_IDLE);
    assign mode_fault              = flags[1];
    assign overrun                 = flags[2];
    assign parity_error            = flags[3];
    assign underrun                = flags[4];
endmodule

//--- tb/spi_format_monitor.sv
`timescale 1ns/1ps
module spi_format_monitor (
    input wire logic         clock,
    input wire logic         srst,
    input wire logic         master_mode,
    input wire logic         three_wire,
    input wire logic         tx_only,
    input wire logic         cpol,
    input wire logic [3:0]   len_code,
    input wire logic         tx_valid,
    input wire logic         tx_ready,
    input wire logic         rx_valid,
    input wire logic         rx_ready,
    input wire logic [127:0] rx_data,
    input wire logic         serial_clock_line_out,
    input wire logic         slave_select_line_n_out,
    input wire logic         busy,
    input wire logic         len_error,
    input wire logic         overrun,
    input wire logic         error_clear
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // Port relations, one per behaviour
    a_sck_idle_level: assert property (master_mode && !busy && $stable(cpol)
        |-> serial_clock_line_out == cpol) else $error("clock not idle");
    a_take_selects: assert property (master_mode && !three_wire && tx_valid && tx_ready
        |=> !slave_select_line_n_out) else $error("no select after take");
    a_lead_quiet: assert property ($fell(slave_select_line_n_out)
        |-> (serial_clock_line_out == cpol)[*2]) else $error("lead too short");
    a_busy_blocks: assert property (master_mode && busy |-> !tx_ready)
        else $error("round taken while busy");
    a_rx_held: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("rx round lost");
    a_txonly_quiet: assert property (tx_only && $past(tx_only)
        |-> !$rose(rx_valid) && !$rose(overrun)) else $error("receive in tx only");
    a_len_flag: assert property (!$past(srst)
        |-> len_error == ($past(len_code) > spi_fmt_pkg::CODE_LEN_32)) else $error("len flag");
    a_overrun_sticky: assert property (overrun && !error_clear |=> overrun)
        else $error("overrun dropped");
endmodule

bind spi_transfer_format_unit spi_format_monitor u_mon (.*);

//--- tb/spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model (
    input  wire logic        sck,
    input  wire logic        sel_n,
    input  wire logic        mosi,
    input  wire logic        cpol,
    input  wire logic        cpha,
    input  wire logic [5:0]  len,
    input  wire logic [31:0] reply,
    output logic             miso,
    output logic [31:0]      got
);
    int idx = 0;

    // Phase 0 shows its first bit at select; a released line shows the inverse
    always @(sel_n) begin
        idx = 0;
        miso = ~miso;
        if (!sel_n && !cpha) begin
            miso = reply[len-1];
            idx = 1;
        end
    end
    // Leading edge leaves the idle level; the same reply repeats every frame
    always @(sck) begin
        if (sel_n === 1'b0) begin
            if ((sck != cpol) ^ cpha) begin
                got = {got[30:0], mosi};
            end else begin
                miso = reply[len-1-(idx%len)];
                idx++;
            end
        end
    end
endmodule

//--- tb/test_spi_transfer_format_unit.sv
`timescale 1ns/1ps
module test_spi_transfer_format_unit;
    logic         clock, srst, tx_only, cpol, cpha, lsb_first, byte_swap, error_clear, parity_en;
    logic         tx_valid, tx_ready, rx_valid, rx_ready, busy, len_error, mode_fault;
    logic         overrun, parity_error, underrun, serial_clock_line_out, serial_clock_line_oe;
    logic         slave_select_line_n_out, slave_select_line_oe, mosi_out, mosi_oe;
    logic         miso_out, miso_oe, miso_in, mosi_in, sck, miso_m;
    logic [3:0]   len_code;
    logic [1:0]   frame_cnt;
    logic [10:0]  clk_div;
    logic [2:0]   lead_delay, trail_delay, next_delay;
    logic [127:0] tx_data, rx_data;
    logic [31:0]  got, reply;
    int           errors = 0, num_checks = 0, l = 8;
    localparam logic [31:0] T = 32'h9e37_79b9;

    // Wire levels from every party's enable
    assign sck = serial_clock_line_oe ? serial_clock_line_out : cpol;
    assign mosi_in = mosi_oe ? mosi_out : 1'b0;
    assign miso_in = miso_oe ? miso_out : miso_m;

    spi_transfer_format_unit u_dut (.*, .master_mode(1'b1), .three_wire(1'b0),
        .parity_odd(1'b0), .slave_select_line_n_in(1'b1), .serial_clock_line_in(sck));
    spi_slave_model u_far (.sck(sck), .sel_n(slave_select_line_oe ? slave_select_line_n_out : 1'b1),
        .mosi(mosi_in), .cpol(cpol), .cpha(cpha), .len(6'(l)), .reply(reply), .miso(miso_m),
        .got(got));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Low l bits, reversed when shifting starts at the LSB
    function automatic logic [31:0] fit(input logic [31:0] x, input int n, input logic lsb);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < n; i++) r[i] = lsb ? x[n-1-i] : x[i];
        return r;
    endfunction

    // Hold the round until taken, then wait out the whole transfer
    task automatic send(input logic [127:0] d);
        int n;
        @(negedge clock);
        tx_data = d;
        tx_valid = 1'b1;
        n = 0;
        while (busy !== 1'b1 && n++ < 1000) @(negedge clock);
        tx_valid = 1'b0;
        while (busy !== 1'b0 && n++ < 5000) @(negedge clock);
        check("busy", busy, 1'b0);
    endtask

    task automatic pop(input logic [127:0] exp);
        int n;
        n = 0;
        @(negedge clock); // An edge between pops keeps rx_ready from two reads at once
        while (rx_valid !== 1'b1 && n++ < 100) @(negedge clock);
        check("rx_data", rx_data, exp);
        rx_ready = 1'b1;
        @(negedge clock);
        rx_ready = 1'b0;
    endtask

    task automatic report_and_stop();
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, far beyond the few thousand cycles needed
    initial begin
        #200000;
        errors++;
        report_and_stop();
    end

    initial begin
        {srst, tx_only, cpol, cpha, lsb_first, byte_swap, error_clear, tx_valid, rx_ready} = 9'h100;
        {len_code, frame_cnt, clk_div} = 17'h0_0003;
        {lead_delay, trail_delay, next_delay} = 9'h000;
        tx_data = '0;
        parity_en = 1'b0;
        reply = 32'h6b2d_c4f1;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        // Every length code, every polarity, phase and bit order
        for (int i = 0; i < 12; i++) begin
            l = i < 9 ? 8 + i : (i == 9 ? 20 : (i == 10 ? 24 : 32));
            len_code = 4'(i);
            {lsb_first, cpol, cpha} = 3'(i);
            send({96'h0, T});
            check("mosi", fit(got, l, lsb_first), fit(T, l, 1'b0));
            pop({96'h0, fit(reply, l, lsb_first)});
        end
        // Two swapped frames with the longest lead
        {lsb_first, cpol, cpha, byte_swap, frame_cnt, lead_delay} = 9'h02f;
        len_code = 4'h8;
        l = 16;
        send({64'h0, 32'h0000_5678, 32'h0000_1234});
        check("mosi", got, 32'h3412_7856);
        pop({64'h0, 32'h0000_f1c4, 32'h0000_f1c4});
        {byte_swap, frame_cnt, lead_delay, len_code} = 10'h00c;
        repeat (2) @(negedge clock);
        check("len_error", len_error, 1'b1);
        len_code = 4'h0;
        l = 8;
        tx_only = 1'b1;
        send({96'h0, T});
        check("mosi", got[7:0], T[7:0]);
        check("rx_valid", rx_valid, 1'b0);
        // Receiver stalls: third round's receive data meets a full buffer and overruns
        tx_only = 1'b0;
        repeat (3) send({96'h0, T});
        check("overrun", overrun, 1'b1);
        repeat (2) pop({120'h0, 8'hf1});
        check("rx_valid", rx_valid, 1'b0);
        error_clear = 1'b1;
        @(negedge clock);
        error_clear = 1'b0;
        @(negedge clock);
        check("overrun", overrun, 1'b0);
        // Even parity takes the last bit sent; the odd reply byte is flagged
        parity_en = 1'b1;
        send({96'h0, T});
        check("mosi", got[7:0], 8'hb8);
        check("parity_error", parity_error, 1'b1);
        report_and_stop();
    end
endmodule
